// *** dv/spac_axis_ctrl_assertions.sv ***
// Concurrent checks on the outputs of the axis control block.
`timescale 1ns/10ps
module spac_axis_chk
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// Observed ports
	input wire logic [31:0] pos_in,
	input wire logic        mech_end_hit,
	input wire logic        home_reached,
	input wire logic        move_go,
	input wire logic        servo_on,
	input wire logic        hold_reduced,
	input wire logic        push_phase,
	input wire logic [7:0]  push_speed_out,
	input wire logic        push_done,
	input wire logic        drive_to_end,
	input wire logic        drive_to_home,
	input wire logic        alarm,
	input wire logic        index_mode,
	input wire logic [31:0] pos_report
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_go_servo_on: assert property (move_go |-> servo_on)
		else $error("move started with servo off");
	a_wake_then_go: assert property ($rose(servo_on) |=> move_go)
		else $error("servo woke without a move");
	a_hold_servo_on: assert property (hold_reduced |-> servo_on)
		else $error("reduced hold with servo off");
	a_push_speed_cap: assert property (push_speed_out <= 8'h14)
		else $error("push speed above cap");
	a_done_in_push: assert property ($rose(push_done) |-> $past(push_phase))
		else $error("push done outside push phase");
	a_end_to_home: assert property ($fell(drive_to_end) |->
		drive_to_home && $past(mech_end_hit))
		else $error("bad turn from end to home");
	a_drives_apart: assert property (!(drive_to_end && drive_to_home))
		else $error("both home drives on");
	a_alarm_cause: assert property ($rose(alarm) |-> $past(home_reached))
		else $error("alarm without home stop");
	a_index_wrap: assert property (index_mode && $past(index_mode) |->
		pos_report < 32'h0000_8CA0)
		else $error("index position out of span");
	a_linear_report: assert property ($past(rstn) && !$past(index_mode) |->
		pos_report == $past(pos_in))
		else $error("reported position differs");
endmodule // spac_axis_chk

bind spac_axis_ctrl spac_axis_chk u_chk (
	.clock(clock), .rstn(rstn), .pos_in(pos_in),
	.mech_end_hit(mech_end_hit), .home_reached(home_reached),
	.move_go(move_go), .servo_on(servo_on), .hold_reduced(hold_reduced),
	.push_phase(push_phase), .push_speed_out(push_speed_out),
	.push_done(push_done), .drive_to_end(drive_to_end),
	.drive_to_home(drive_to_home), .alarm(alarm),
	.index_mode(index_mode), .pos_report(pos_report));

// *** dv/spac_plc_model.sv ***
// Behavioural PLC that pulses the movement and home command pins.
`timescale 1ns/10ps
module spac_plc_model
(
	// Clock
	input wire logic clock,
	// Command pins
	output logic     start_cmd_pin,
	output logic     home_cmd_pin
);
	initial
	begin
		start_cmd_pin = 1'b0;
		home_cmd_pin  = 1'b0;
	end
	// The level is held past the input sync, then dropped for a fresh edge.
	task automatic press(input logic home);
		@(posedge clock);
		home_cmd_pin  <= home;
		start_cmd_pin <= !home;
		repeat (5) @(posedge clock);
		home_cmd_pin  <= 1'b0;
		start_cmd_pin <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
endmodule // spac_plc_model

// *** dv/standstill_push_axis_control_test.sv ***
// Self-checking bench for the standstill, push and axis control block.
`timescale 1ns/10ps
`include "spac_defines.svh"
module standstill_push_axis_control_test;
	logic        clock, rstn, start_cmd_pin, home_cmd_pin, home_sensor_pin;
	logic [7:0]  awaddr, araddr, push_speed_out;
	logic [31:0] wdata, rdata, pos_in, pos_report, v;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, entry_push, pos_done;
	logic        at_target, cur_ge_limit, torque_over, mech_end_hit;
	logic        home_reached, servo_on, hold_reduced, push_done, load_out;
	logic        drive_to_end, drive_to_home, rotational, shortcut_path;
	logic        deadman_pin, in_range, deadman_stop, index_mode, band_default;
	logic [2:0]  entry_std;
	logic [31:0] exp_q[$], mask_q[$];
	int          n_mismatch, compares, i;
	logic [7:0]  ra [0:7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h30};
	logic [31:0] re [0:7] = '{32'h0000_0008, 32'h0, 32'h0, 32'h0,
		32'h0000_0005, 32'h0000_00FF, 32'h0000_00FF, 32'h0};

	spac_plc_model plc (.clock(clock), .start_cmd_pin(start_cmd_pin),
		.home_cmd_pin(home_cmd_pin));
	spac_axis_ctrl #(.MS_CYCLES(4)) dut (
		.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .start_cmd_pin(start_cmd_pin),
		.home_cmd_pin(home_cmd_pin), .home_sensor_pin(home_sensor_pin),
		.deadman_pin(deadman_pin), .entry_standstill(entry_std),
		.entry_push(entry_push), .pos_done(pos_done),
		.at_target(at_target), .cur_ge_limit(cur_ge_limit),
		.torque_over(torque_over), .torque_in_range(in_range),
		.mech_end_hit(mech_end_hit), .home_reached(home_reached),
		.pos_in(pos_in), .move_go(), .servo_on(servo_on),
		.hold_reduced(hold_reduced), .push_phase(),
		.push_speed_out(push_speed_out), .push_done(push_done),
		.load_out(load_out), .drive_to_end(drive_to_end),
		.drive_to_home(drive_to_home), .alarm(),
		.deadman_stop(deadman_stop),
		.rotational(rotational), .index_mode(index_mode),
		.shortcut_path(shortcut_path), .band_default(band_default),
		.pos_report(pos_report));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clock);
		exp_q.push_back(e & m);
		mask_q.push_back(m);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
	endtask

	task automatic pulse_done();
		pos_done <= 1'b1;
		@(posedge clock);
		pos_done <= 1'b0;
	endtask

	task automatic home_run(input logic flip);
		int t;
		plc.press(1'b1);
		for (t = 0; t < 40 && !drive_to_end; t++) @(posedge clock);
		chk({31'h0, drive_to_end}, 32'h1);
		repeat (3) @(posedge clock);
		mech_end_hit <= 1'b1;
		@(posedge clock);
		mech_end_hit    <= 1'b0;
		home_sensor_pin <= home_sensor_pin ^ flip;
		for (t = 0; t < 40 && !drive_to_home; t++) @(posedge clock);
		repeat (4) @(posedge clock);
		home_reached <= 1'b1;
		@(posedge clock);
		home_reached <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	// Read results are compared here as they come back.
	always @(posedge clock)
		if (rvalid && rready && exp_q.size() > 0)
			chk(rdata & mask_q.pop_front(), exp_q.pop_front());

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		{rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, pos_in} = '0;
		{entry_push, pos_done, at_target, cur_ge_limit} = '0;
		{torque_over, mech_end_hit, home_reached, home_sensor_pin} = '0;
		{deadman_pin, in_range, entry_std} = 5'h10;
		v = $urandom(99990);
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		for (i = 0; i < 8; i++)
			rd(ra[i], re[i], 32'hFFFF_FFFF);
		v = 32'h0000_0015 + ($urandom % 235);
		wr(8'h10, v);
		chk({24'h0, push_speed_out}, 32'h0000_0014);
		wr(8'h10, 32'h0000_000C);
		chk({24'h0, push_speed_out}, 32'h0000_000C);
		wr(8'h14, 32'h0000_FFFF);
		rd(8'h14, 32'h0000_270F, 32'hFFFF_FFFF);
		wr(8'h00, 32'h0000_0019);
		for (i = 1; i < 4; i++)
			wr(8'(4 * i), 32'(i));
		home_run(1'b0);
		rd(8'h1C, 32'h0000_2008, 32'h0000_2008);
		wr(8'h24, 32'h0000_0001);
		rd(8'h1C, 32'h0, 32'h0000_0008);
		home_run(1'b1);
		rd(8'h1C, 32'h0000_1000, 32'h0000_1008);
		for (i = 0; i < 6; i++)
		begin
			wr(8'h00, 32'h0000_0018 | (i == 5 ? 32'h0000_1401 : 32'(i)));
			plc.press(1'b0);
			chk({31'h0, servo_on}, 32'h1);
			pulse_done();
			repeat (20) @(posedge clock);
			chk({31'h0, servo_on}, 32'(!(i inside {[1:3]})));
			if (i < 5) chk({31'h0, hold_reduced}, 32'(i == 4));
		end
		wr(8'h00, 32'h0000_2058);
		wr(8'h14, 32'h0000_0004);
		wr(8'h18, 32'h0000_0002);
		entry_push  <= 1'b1;
		torque_over <= 1'b1;
		plc.press(1'b0);
		at_target <= 1'b1;
		@(posedge clock);
		at_target <= 1'b0;
		@(posedge clock);
		cur_ge_limit <= 1'b1;
		repeat (12) @(posedge clock);
		cur_ge_limit <= 1'b0;
		repeat (8) @(posedge clock);
		cur_ge_limit <= 1'b1;
		repeat (8) @(posedge clock);
		chk({31'h0, push_done}, 32'h0);
		repeat (8) @(posedge clock);
		chk({31'h0, push_done}, 32'h1);
		chk({31'h0, load_out}, 32'h1);
		{entry_push, torque_over, cur_ge_limit} <= '0;
		entry_std <= 3'h3;
		plc.press(1'b0);
		chk({31'h0, push_done}, 32'h0);
		pulse_done();
		v = `SPAC_INDEX_SPAN * ($urandom % 4) + ($urandom % 36000);
		pos_in <= v;
		repeat (3) @(posedge clock);
		chk(pos_report, v);
		wr(8'h00, 32'h0000_0398);
		repeat (3) @(posedge clock);
		chk(pos_report, v % `SPAC_INDEX_SPAN);
		v = {28'h0, rotational, shortcut_path, index_mode, band_default};
		chk(v, 32'h0000_000F);
		deadman_pin <= 1'b0;
		wr(8'h00, 32'h0000_0390);
		repeat (2) @(posedge clock);
		chk({31'h0, deadman_stop}, 32'h0000_0001);
		chk({31'h0, servo_on}, 32'h0000_0000);
		repeat (4) @(posedge clock);
		end_sim();
	end
endmodule // standstill_push_axis_control_test

// *** include/spac_acc_if.sv ***
// Interface between the control logic and a millisecond time accumulator.
`timescale 1ns/10ps
interface spac_acc_if;
	import spac_pkg::*;
	logic     tick;
	logic     clear;
	logic     up;
	logic     down_en;
	spac_ms_t limit;
	spac_ms_t count;
	logic     reached;
	modport ctl (output tick, clear, up, down_en, limit,
		input count, reached);
	modport acc (input tick, clear, up, down_en, limit,
		output count, reached);
endinterface

// *** include/spac_defines.svh ***
// Offsets, field positions, reset values and timing counts of the block.
`ifndef SPAC_DEFINES_SVH
`define SPAC_DEFINES_SVH

`define SPAC_CLK_NS        100
`define SPAC_MS_NS         1000000

`define SPAC_OFF_CTRL      8'h00
`define SPAC_OFF_DLY1      8'h04
`define SPAC_OFF_DLY2      8'h08
`define SPAC_OFF_DLY3      8'h0C
`define SPAC_OFF_PUSHV     8'h10
`define SPAC_OFF_PUSHT     8'h14
`define SPAC_OFF_LOADT     8'h18
`define SPAC_OFF_STAT      8'h1C
`define SPAC_OFF_POS       8'h20
`define SPAC_OFF_CMD       8'h24

`define SPAC_F_STAND_LO    0
`define SPAC_F_DEADMAN     3
`define SPAC_F_POL_LO      4
`define SPAC_F_TORQUE_RANGE_SELECT        6
`define SPAC_F_AXIS        7
`define SPAC_F_ROTMODE     8
`define SPAC_F_SHORTCUT    9
`define SPAC_F_PAT_LO      10
`define SPAC_F_TRQCHK      13
`define SPAC_CTRL_MASK     32'h0000_3FFF
`define SPAC_CTRL_RST      32'h0000_0008

`define SPAC_PUSH_MAX_MMS  8'h14
`define SPAC_JUDGE_MAX     14'h270F
`define SPAC_JUDGE_RST     14'h00FF
`define SPAC_DLY_RST       16'h0000
`define SPAC_PUSHV_RST     8'h05
`define SPAC_INDEX_SPAN    32'h0000_8CA0

`endif

// *** include/spac_pkg.sv ***
// Types shared by the standstill, push and axis control modules.
package spac_pkg;
	typedef logic [13:0] spac_ms_t;
	typedef enum logic [1:0] {SRV_ON, SRV_WAIT, SRV_OFF, SRV_WAKE} spac_srv_e;
	typedef enum logic [1:0] {HOME_IDLE, HOME_TO_END, HOME_TO_HOME} spac_home_e;
endpackage

// *** verilog/spac_axis_ctrl.sv ***
// Standstill power saving, push and hold, home check and axis control.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "spac_defines.svh"

module spac_axis_ctrl
	import spac_pkg::*;
#(
	parameter int MS_CYCLES = `SPAC_MS_NS / `SPAC_CLK_NS
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// AXI4-Lite register slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// PLC and sensor pins
	input  wire logic        start_cmd_pin,
	input  wire logic        home_cmd_pin,
	input  wire logic        home_sensor_pin,
	input  wire logic        deadman_pin,
	// Motion core status
	input  wire logic [2:0]  entry_standstill,
	input  wire logic        entry_push,
	input  wire logic        pos_done,
	input  wire logic        at_target,
	input  wire logic        cur_ge_limit,
	input  wire logic        torque_over,
	input  wire logic        torque_in_range,
	input  wire logic        mech_end_hit,
	input  wire logic        home_reached,
	input  wire logic [31:0] pos_in,
	// Motion core commands
	output logic             move_go,
	output logic             servo_on,
	output logic             hold_reduced,
	output logic             push_phase,
	output logic [7:0]       push_speed_out,
	output logic             push_done,
	output logic             load_out,
	output logic             drive_to_end,
	output logic             drive_to_home,
	output logic             alarm,
	output logic             deadman_stop,
	output logic             rotational,
	output logic             index_mode,
	output logic             shortcut_path,
	output logic             band_default,
	output logic [31:0]      pos_report
);
	// Register file.
	logic [31:0] ctrl_reg;
	logic [15:0] dly_reg [3];
	logic [7:0]  pushv_reg;
	spac_ms_t    pusht_reg;
	spac_ms_t    loadt_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic        bvalid_reg;
	logic [31:0] rdata_reg;
	logic        rvalid_reg;

	// Control state.
	logic [3:0]  sync2_reg;
	logic [1:0]  edge_reg;
	spac_srv_e   srv_reg;
	spac_home_e  home_reg;
	logic [15:0] dly_cnt_reg;
	logic [13:0] ms_cnt_reg;
	logic        tick_reg;
	logic        homed_reg;
	logic        moving_reg;
	logic        std_sel_reg;
	logic [2:0]  mode_reg;
	logic        push_move_reg;
	logic        push_phase_reg;
	logic        go_reg;
	logic        sens_end_reg;
	logic        alarm_reg;
	logic        home_err_reg;
	logic        push_done_d_reg;
	logic [31:0] pos_reg;

	spac_acc_if push_acc ();
	spac_acc_if load_acc ();

	// Converts a home sensor level to its active sense.
	function automatic logic sens_active(input logic [1:0] pol,
		input logic lvl);
		sens_active = (pol == 2'd2) ? !lvl : lvl;
	endfunction

	// Decode of an address against a register offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a[7:2] == o[7:2]);
	endfunction

	// Configuration fields.
	wire [2:0] std_sel  = ctrl_reg[`SPAC_F_STAND_LO +: 3];
	wire       dm_off   = ctrl_reg[`SPAC_F_DEADMAN];
	wire [1:0] pol      = ctrl_reg[`SPAC_F_POL_LO +: 2];
	wire       torque_range_select     = ctrl_reg[`SPAC_F_TORQUE_RANGE_SELECT];
	wire       axis_rot = ctrl_reg[`SPAC_F_AXIS];
	wire       rot_idx  = ctrl_reg[`SPAC_F_ROTMODE];
	wire       short_en = ctrl_reg[`SPAC_F_SHORTCUT];
	wire [2:0] pattern  = ctrl_reg[`SPAC_F_PAT_LO +: 3];
	wire       trq_chk  = ctrl_reg[`SPAC_F_TRQCHK];

	// Synchronised pins: start, home, sensor, deadman.
	wire [3:0] pin_raw = {deadman_pin, home_sensor_pin, home_cmd_pin,
		start_cmd_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			logic s1_reg;
			logic s2_reg;
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end
				else
				begin
					s1_reg <= pin_raw[gi];
					s2_reg <= s1_reg;
				end
			end
			assign sync2_reg[gi] = s2_reg;
		end
	endgenerate

	wire start_rise = sync2_reg[0] && !edge_reg[0];
	wire home_rise  = sync2_reg[1] && !edge_reg[1];
	wire sens_now   = sens_active(pol, sync2_reg[2]);

	assign deadman_stop = !dm_off && !sync2_reg[3];
	wire   homing       = (home_reg != HOME_IDLE);
	wire   move_req     = start_rise && !deadman_stop && !homing;

	// Standstill mode: a position entry overrides the default setting, except under pattern 5.
	wire [2:0] mode_raw  = (entry_standstill != 3'd0) ? entry_standstill
		: std_sel;
	wire       pat5      = (pattern == 3'd5);
	wire [2:0] mode_eff  = pat5 ? ((std_sel == 3'd4) ? 3'd4 : 3'd0)
		: mode_raw;
	wire       armed     = pat5 || homed_reg;
	wire       mode_auto = (mode_reg >= 3'd1) && (mode_reg <= 3'd3);
	wire [15:0] dly_pick = (mode_reg == 3'd1) ? dly_reg[0] :
		(mode_reg == 3'd2) ? dly_reg[1] : dly_reg[2];

	wire push_done_rise = push_acc.reached && !push_done_d_reg;
	wire complete_evt   = moving_reg && (pos_done || push_done_rise);

	// Axis type and index mode.
	assign rotational    = axis_rot;
	assign index_mode    = axis_rot && rot_idx;
	assign shortcut_path = index_mode && short_en;
	assign band_default  = index_mode;
	wire   push_allowed  = entry_push && !index_mode && !pat5;

	// Torque threshold, optionally qualified by the check range.
	wire trq_hit = torque_over && (torque_range_select || torque_in_range);

	// Push judgment counts down while current is low.
	assign push_acc.tick    = tick_reg && push_phase_reg;
	assign push_acc.clear   = go_reg;
	assign push_acc.up      = cur_ge_limit;
	assign push_acc.down_en = 1'b1;
	assign push_acc.limit   = pusht_reg;

	// Load time only accumulates.
	assign load_acc.tick    = tick_reg && push_phase_reg && trq_chk;
	assign load_acc.clear   = go_reg;
	assign load_acc.up      = trq_hit;
	assign load_acc.down_en = 1'b0;
	assign load_acc.limit   = loadt_reg;

	spac_time_acc u_push_acc (
		.clock (clock),
		.rstn  (rstn),
		.acc   (push_acc)
	);

	spac_time_acc u_load_acc (
		.clock (clock),
		.rstn  (rstn),
		.acc   (load_acc)
	);

	// Millisecond tick.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ms_cnt_reg <= '0;
			tick_reg   <= 1'b0;
		end
		else
		begin
			tick_reg   <= (ms_cnt_reg == 14'(MS_CYCLES - 1));
			ms_cnt_reg <= (ms_cnt_reg == 14'(MS_CYCLES - 1)) ? '0
				: ms_cnt_reg + 14'h0001;
		end
	end

	// Servo standstill state machine.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			srv_reg     <= SRV_ON;
			dly_cnt_reg <= '0;
			go_reg      <= 1'b0;
		end
		else
		begin
			go_reg <= 1'b0;
			case (srv_reg)
				SRV_ON:
				begin
					if (move_req)
						go_reg <= 1'b1;
					else if (complete_evt && armed && mode_auto)
					begin
						dly_cnt_reg <= dly_pick;
						srv_reg     <= (dly_pick == '0) ? SRV_OFF
							: SRV_WAIT;
					end
				end
				SRV_WAIT:
				begin
					if (move_req)
					begin
						go_reg  <= 1'b1;
						srv_reg <= SRV_ON;
					end
					else if (tick_reg && dly_cnt_reg == 16'h0001)
						srv_reg <= SRV_OFF;
					else if (tick_reg)
						dly_cnt_reg <= dly_cnt_reg - 16'h0001;
				end
				SRV_OFF:
				begin
					if (move_req || home_rise)
						srv_reg <= SRV_WAKE;
				end
				SRV_WAKE:
				begin
					go_reg  <= !homing;
					srv_reg <= SRV_ON;
				end
				default: srv_reg <= SRV_ON;
			endcase
		end
	end

	// Move, push and standstill mode progress.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			edge_reg        <= '0;
			moving_reg      <= 1'b0;
			std_sel_reg     <= 1'b0;
			mode_reg        <= '0;
			push_move_reg   <= 1'b0;
			push_phase_reg  <= 1'b0;
			push_done_d_reg <= 1'b0;
		end
		else
		begin
			edge_reg        <= sync2_reg[1:0];
			push_done_d_reg <= push_acc.reached;
			if (go_reg)
			begin
				moving_reg     <= 1'b1;
				mode_reg       <= mode_eff;
				push_move_reg  <= push_allowed;
				push_phase_reg <= 1'b0;
			end
			else if (complete_evt)
			begin
				moving_reg     <= 1'b0;
				push_phase_reg <= 1'b0;
			end
			else if (at_target && push_move_reg && moving_reg)
				push_phase_reg <= 1'b1;
			std_sel_reg <= (mode_reg == 3'd4) && armed;
		end
	end

	// Home return with optional check sensor.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			home_reg     <= HOME_IDLE;
			homed_reg    <= 1'b0;
			sens_end_reg <= 1'b0;
			home_err_reg <= 1'b0;
		end
		else
		begin
			case (home_reg)
				HOME_IDLE:
				begin
					if (home_rise && !deadman_stop)
						home_reg <= (pol == 2'd0) ? HOME_TO_HOME
							: HOME_TO_END;
				end
				HOME_TO_END:
				begin
					if (mech_end_hit)
					begin
						sens_end_reg <= sens_now;
						home_reg     <= HOME_TO_HOME;
					end
				end
				HOME_TO_HOME:
				begin
					if (home_reached)
					begin
						home_reg <= HOME_IDLE;
						if (pol != 2'd0 && sens_now == sens_end_reg)
							home_err_reg <= 1'b1;
						else
						begin
							home_err_reg <= 1'b0;
							homed_reg    <= 1'b1;
						end
					end
				end
				default: home_reg <= HOME_IDLE;
			endcase
		end
	end

	// Index position wrap.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			pos_reg <= '0;
		else
			pos_reg <= index_mode ? (pos_in % `SPAC_INDEX_SPAN)
				: pos_in;
	end

	// Register writes.
	wire        wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	wire [31:0] wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	wire [13:0] wr_ms   = (wdata_reg > 32'(`SPAC_JUDGE_MAX))
		? `SPAC_JUDGE_MAX : wdata_reg[13:0];
	wire        alarm_clr = wr_fire && hit(awaddr_reg, `SPAC_OFF_CMD)
		&& wdata_reg[0];

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			bvalid_reg  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_reg  <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_reg  <= s_axi_wdata & wmask;
				w_held_reg <= 1'b1;
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_reg  <= `SPAC_CTRL_RST;
			dly_reg   <= '{default: `SPAC_DLY_RST};
			pushv_reg <= `SPAC_PUSHV_RST;
			pusht_reg <= `SPAC_JUDGE_RST;
			loadt_reg <= `SPAC_JUDGE_RST;
		end
		else if (wr_fire)
		begin
			if (hit(awaddr_reg, `SPAC_OFF_CTRL))
				ctrl_reg <= wdata_reg & `SPAC_CTRL_MASK;
			if (hit(awaddr_reg, `SPAC_OFF_DLY1))
				dly_reg[0] <= wdata_reg[15:0];
			if (hit(awaddr_reg, `SPAC_OFF_DLY2))
				dly_reg[1] <= wdata_reg[15:0];
			if (hit(awaddr_reg, `SPAC_OFF_DLY3))
				dly_reg[2] <= wdata_reg[15:0];
			if (hit(awaddr_reg, `SPAC_OFF_PUSHV))
				pushv_reg <= wdata_reg[7:0];
			if (hit(awaddr_reg, `SPAC_OFF_PUSHT))
				pusht_reg <= wr_ms;
			if (hit(awaddr_reg, `SPAC_OFF_LOADT))
				loadt_reg <= wr_ms;
		end
	end

	// Alarm: a new sensor error wins over a clear in the same cycle.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			alarm_reg <= 1'b0;
		else
			alarm_reg <= (home_reg == HOME_TO_HOME && home_reached &&
				pol != 2'd0 && sens_now == sens_end_reg) ||
				(alarm_reg && !alarm_clr);
	end

	// Register reads.
	wire [31:0] stat_word = {18'h0_0000, home_err_reg, homed_reg,
		load_acc.reached, push_acc.reached, push_phase_reg, moving_reg,
		2'(home_reg), 2'(srv_reg), alarm_reg, std_sel_reg, servo_on,
		sync2_reg[2]};
	wire [31:0] rd_word =
		hit(s_axi_araddr, `SPAC_OFF_CTRL)  ? ctrl_reg :
		hit(s_axi_araddr, `SPAC_OFF_DLY1)  ? {16'h0000, dly_reg[0]} :
		hit(s_axi_araddr, `SPAC_OFF_DLY2)  ? {16'h0000, dly_reg[1]} :
		hit(s_axi_araddr, `SPAC_OFF_DLY3)  ? {16'h0000, dly_reg[2]} :
		hit(s_axi_araddr, `SPAC_OFF_PUSHV) ? {24'h00_0000, pushv_reg} :
		hit(s_axi_araddr, `SPAC_OFF_PUSHT) ? {18'h0_0000, pusht_reg} :
		hit(s_axi_araddr, `SPAC_OFF_LOADT) ? {18'h0_0000, loadt_reg} :
		hit(s_axi_araddr, `SPAC_OFF_STAT)  ? stat_word :
		hit(s_axi_araddr, `SPAC_OFF_POS)   ? pos_reg : 32'h0000_0000;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_reg  <= '0;
			rvalid_reg <= 1'b0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rdata_reg  <= rd_word;
			rvalid_reg <= 1'b1;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = 2'b00;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = 2'b00;

	// Outputs toward the motion core.
	assign move_go        = go_reg;
	assign servo_on       = (srv_reg != SRV_OFF);
	assign hold_reduced   = std_sel_reg && !moving_reg;
	assign push_phase     = push_phase_reg;
	assign push_speed_out = (pushv_reg > `SPAC_PUSH_MAX_MMS)
		? `SPAC_PUSH_MAX_MMS : pushv_reg;
	assign push_done      = push_acc.reached;
	assign load_out       = load_acc.reached;
	assign drive_to_end   = (home_reg == HOME_TO_END);
	assign drive_to_home  = (home_reg == HOME_TO_HOME);
	assign alarm          = alarm_reg;
	assign pos_report     = pos_reg;
endmodule // spac_axis_ctrl

// *** verilog/spac_time_acc.sv ***
// Millisecond accumulator that counts up, optionally down, toward a limit.
`timescale 1ns/10ps
module spac_time_acc
	import spac_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Control side
	spac_acc_if.acc  acc
);
	spac_ms_t count_reg;
	spac_ms_t count_next;
	logic     reached_reg;
	wire      inc = acc.tick && acc.up && (count_reg < acc.limit);
	wire      dec = acc.tick && !acc.up && acc.down_en && (count_reg != '0);

	// Clear wins, and the count never goes below zero.
	assign count_next = acc.clear ? '0 :
		inc ? count_reg + 14'h0001 :
		dec ? count_reg - 14'h0001 : count_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			count_reg   <= '0;
			reached_reg <= 1'b0;
		end
		else
		begin
			count_reg   <= count_next;
			reached_reg <= !acc.clear && (count_next >= acc.limit);
		end
	end

	assign acc.count   = count_reg;
	assign acc.reached = reached_reg;
endmodule // spac_time_acc
